// ### src/ces_sched.sv
// Channel event scheduler: ids, interrupts, timers, master clear, dispatch
`timescale 1ns/10ps
`default_nettype none
`include "ces_cfg.svh"
module ces_sched #(
    parameter int TICK_CYC = `CES_TICK_CYC,
    parameter logic [15:0] BASIC_ID = 16'h5a5a // Arbitrary value
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_B,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Pins from switches, adapters and bus
    input wire logic [4:0] GROUP_SW,
    input wire logic [31:0] SVC_REQ,
    input wire logic BUS_ACK,
    input wire logic BUS_NAK,
    input wire logic BUS_RETRY,
    input wire logic [7:0] ADP_ID,
    input wire logic [7:0] PACK_ID,
    input wire logic ADP_PRESENT,
    input wire logic ADP_PAR_ONLY,
    input wire logic ADP_FW_BAD,
    // Interrupt transfer and master clear
    output logic INT_REQ,
    output logic [9:0] INT_SRC,
    output logic [15:0] INT_WORD,
    output logic MCLR,
    output logic [4:0] ID_CHAN,
    // Program engine events
    input wire logic EV_STB,
    input wire ces_pkg::ces_ev_e EV_CODE,
    input wire logic [4:0] EV_CHAN,
    input wire logic [7:0] EV_ARG,
    // Context restore and start
    input wire logic CTX_DONE,
    output logic CTX_REQ,
    output logic [4:0] CTX_CHAN,
    output logic CTX_FIRST,
    output logic PGM_GO
);
    localparam int TW = $clog2(TICK_CYC + 1);

    // Lowest set bit, with found flag on top
    function automatic logic [5:0] pick(input logic [31:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction

    // Pin synchronisers
    logic [58:0] s1_ff, s2_ff;
    logic [31:0] svc_d_ff;
    logic rty_d_ff;
    logic [4:0] grp;
    logic [31:0] svc;
    logic ack_p, nak_p, rty_p;
    logic [7:0] adp_p, pack_p;
    logic pres_p, par_p, bad_p;
    assign {grp, svc, ack_p, nak_p, rty_p, adp_p, pack_p, pres_p, par_p, bad_p} = s2_ff;

    // Bus state
    logic ack_ff, nxt_ack, mode_ff, nxt_mode, mclr_ff, nxt_mclr;
    logic [31:0] dat_ff, nxt_dat, tact_ff, nxt_tact;
    logic [15:0] resp_ff, nxt_resp;
    logic [4:0] chsel_ff, nxt_chsel;
    logic [3:0] sec_ff, nxt_sec;
    logic [11:0] mcc_ff, nxt_mcc;
    logic [15:0] la_ff [32], nxt_la [32], lb_ff [32], nxt_lb [32];
    // Interrupt state
    logic [31:0] pend_ff, nxt_pend, pb_ff, nxt_pb, defr_ff, nxt_defr;
    logic [31:0] rtd_ff, nxt_rtd;
    logic [7:0] dcnt_ff, nxt_dcnt;
    logic irq_ff, nxt_irq;
    logic [4:0] ich_ff, nxt_ich;
    logic [15:0] iw_ff, nxt_iw;
    // Dispatcher state
    ces_pkg::ces_st_e st_ff, nxt_st;
    logic [31:0] stp_ff, nxt_stp, begun_ff, nxt_begun;
    logic [15:0] lr2_ff, nxt_lr2;
    logic [4:0] run_ff, nxt_run;
    logic go_ff, nxt_go, first_ff, nxt_first, ctxr_ff, nxt_ctxr;
    // Tick divider
    logic [TW-1:0] tick_ff, nxt_tick;
    logic tick;
    // Decoded pulses
    logic acc, wr, ord_wr, tmr_wr;
    logic [5:0] fc;
    logic [4:0] och;
    logic [31:0] och_h, ev_h, tmr_ld, tmr_stop, tout, intset, intb, startset;
    logic [3:0] sec_set;
    logic [7:0] tmr_v [32];
    logic [7:0] adp_b;

    // Two flops per pin, third for edges
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            s1_ff <= 59'h0;
            s2_ff <= 59'h0;
            svc_d_ff <= 32'h0;
            rty_d_ff <= 1'b0;
        end else begin
            s1_ff <= {GROUP_SW, SVC_REQ, BUS_ACK, BUS_NAK, BUS_RETRY, ADP_ID,
                PACK_ID, ADP_PRESENT, ADP_PAR_ONLY, ADP_FW_BAD};
            s2_ff <= s1_ff;
            svc_d_ff <= svc;
            rty_d_ff <= rty_p;
        end
    end

    // Per-channel countdown timers
    for (genvar c = 0; c < 32; c++) begin : g_tmr
        logic [7:0] t_ff, nxt_t;
        logic to;
        // Stop wins over load, load over count
        always_comb begin
            nxt_t = t_ff;
            to = 1'b0;
            if (tmr_stop[c]) begin
                nxt_t = 8'h00;
            end else if (tmr_ld[c]) begin
                nxt_t = WB_DAT_I[7:0];
            end else if (tick && t_ff != 8'h00) begin
                nxt_t = t_ff - 8'h01;
                to = (t_ff == 8'h01);
            end
        end
        // Timer register
        always_ff @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
                t_ff <= 8'h00;
            end else begin
                t_ff <= nxt_t;
            end
        end
        assign tmr_v[c] = t_ff;
        assign tout[c] = to;
    end

    // Request decode from bus and engine
    always_comb begin
        acc = WB_CYC_I && WB_STB_I && !ack_ff;
        wr = acc && WB_WE_I && WB_SEL_I == 4'hf;
        ord_wr = wr && WB_ADR_I == `CES_A_ORDER;
        tmr_wr = wr && WB_ADR_I == `CES_A_TIMER;
        fc = WB_DAT_I[`CES_ORD_FC];
        och = WB_DAT_I[`CES_ORD_CH];
        och_h = 32'h1 << och;
        ev_h = EV_STB ? (32'h1 << EV_CHAN) : 32'h0;
        tmr_ld = tmr_wr ? (32'h1 << chsel_ff) : 32'h0;
        tmr_stop = 32'h0;
        intset = 32'h0;
        intb = 32'h0;
        sec_set = 4'h0;
        startset = (svc & ~svc_d_ff) | tout;
        nxt_tick = (tick_ff == TW'(TICK_CYC - 1)) ? '0 : tick_ff + 1'b1;
        tick = (tick_ff == TW'(TICK_CYC - 1));
        // Orders are told apart by function code only
        if (ord_wr) begin
            unique case (fc)
                `CES_FC_CHCTL: begin
                    if (WB_DAT_I[16]) begin
                        startset = startset | och_h;
                    end else begin
                        tmr_stop = och_h;
                    end
                end
                `CES_FC_RAMRD, `CES_FC_RAMWR: begin
                    sec_set[`CES_SEC_RAM] = 1'b1;
                    intb = och_h;
                end
                `CES_FC_INTA, `CES_FC_INTB, `CES_FC_EXTID, `CES_FC_BASID,
                `CES_FC_CTRL, `CES_FC_RAMCTL: begin
                end
                default: begin
                    sec_set[`CES_SEC_ILLIO] = 1'b1;
                    intb = och_h;
                end
            endcase
        end
        // Engine events
        if (EV_STB) begin
            unique case (EV_CODE)
                ces_pkg::EV_BLOCK, ces_pkg::EV_PROGRAM_INTERRUPT_INSTRUCTION: intset = ev_h;
                ces_pkg::EV_DSS: begin
                    if (EV_ARG[`CES_ARG_INT]) begin
                        intset = ev_h;
                    end
                    if (EV_ARG[`CES_ARG_SCAN] && EV_ARG[`CES_ARG_START]) begin
                        startset = startset | ev_h;
                    end
                end
                ces_pkg::EV_CCB: intset = (!mode_ff && EV_ARG[`CES_ARG_IBIT]) ? ev_h : 32'h0;
                ces_pkg::EV_BLOCK_HANDOVER_INSTRUCTION: intset = (mode_ff && EV_ARG[`CES_ARG_IBIT]) ? ev_h : 32'h0;
                ces_pkg::EV_LR2: begin
                    if (EV_ARG[`CES_ARG_TX] && !lr2_ff[EV_CHAN[4:1]]) begin
                        startset = startset | (32'h1 << {EV_CHAN[4:1], 1'b1});
                    end
                end
                ces_pkg::EV_SWINT: begin
                    if (EV_ARG[`CES_ARG_SWI] != 3'h0) begin
                        startset = startset | ev_h;
                    end
                end
                ces_pkg::EV_ILL: begin
                    sec_set[`CES_SEC_ILLPG] = 1'b1;
                    intb = intb | ev_h;
                end
                ces_pkg::EV_PAR: begin
                    sec_set[`CES_SEC_PAR] = 1'b1;
                    intb = intb | ev_h;
                end
                ces_pkg::EV_WAIT: begin
                end
            endcase
        end
        intset = intset | intb;
        // Adapter byte of extended id
        adp_b = !pres_p ? 8'h00 : (par_p ? 8'h01 : adp_p);
        adp_b[7] = adp_b[7] | bad_p;
    end

    // Register file, orders and master clear
    always_comb begin
        nxt_ack = acc;
        nxt_dat = dat_ff;
        nxt_mode = mode_ff;
        nxt_chsel = chsel_ff;
        nxt_resp = resp_ff;
        nxt_la = la_ff;
        nxt_lb = lb_ff;
        nxt_sec = sec_ff | sec_set;
        nxt_tact = tact_ff | tout;
        nxt_mclr = mclr_ff;
        nxt_mcc = mcc_ff;
        // Read mux, zero for unmapped
        if (acc) begin
            case (WB_ADR_I)
                `CES_A_ID: nxt_dat = {16'h0, BASIC_ID};
                `CES_A_CTRL: nxt_dat = {30'h0, mclr_ff, mode_ff};
                `CES_A_RESP: nxt_dat = {16'h0, resp_ff};
                `CES_A_CHSEL: nxt_dat = {27'h0, chsel_ff};
                `CES_A_TIMER: nxt_dat = {24'h0, tmr_v[chsel_ff]};
                `CES_A_SEC: nxt_dat = {28'h0, sec_ff};
                `CES_A_TACT: nxt_dat = tact_ff;
                `CES_A_DEFCNT: nxt_dat = {24'h0, dcnt_ff};
                default: nxt_dat = 32'h0;
            endcase
        end
        // Writes; clears lose to same-cycle sets
        if (wr) begin
            case (WB_ADR_I)
                `CES_A_CTRL: begin
                    nxt_mode = WB_DAT_I[`CES_CTRL_MODE];
                    if (WB_DAT_I[`CES_CTRL_MC] && !mclr_ff) begin
                        nxt_mclr = 1'b1;
                        nxt_mcc = 12'h000;
                    end
                end
                `CES_A_CHSEL: nxt_chsel = WB_DAT_I[4:0];
                `CES_A_SEC: nxt_sec = (sec_ff & ~WB_DAT_I[3:0]) | sec_set;
                `CES_A_TACT: nxt_tact = (tact_ff & ~WB_DAT_I) | tout;
            endcase
        end
        // Order side effects
        if (ord_wr) begin
            case (fc)
                `CES_FC_INTA: nxt_la[och] = WB_DAT_I[`CES_ORD_DAT];
                `CES_FC_INTB: nxt_lb[och] = WB_DAT_I[`CES_ORD_DAT];
                `CES_FC_BASID: nxt_resp = BASIC_ID;
                `CES_FC_EXTID: nxt_resp = {adp_b, pack_p};
            endcase
        end
        // Master clear hold count
        if (mclr_ff) begin
            nxt_mcc = mcc_ff + 12'h001;
            if (mcc_ff == 12'(`CES_MC_CYC - 1)) begin
                nxt_mclr = 1'b0;
            end
        end
    end

    // Interrupt transfer with deferred retry
    always_comb begin
        logic [5:0] s;
        s = pick(pend_ff & ~defr_ff);
        nxt_pend = pend_ff;
        nxt_pb = pb_ff;
        nxt_defr = defr_ff;
        nxt_rtd = rtd_ff;
        nxt_dcnt = dcnt_ff;
        nxt_irq = irq_ff;
        nxt_ich = ich_ff;
        nxt_iw = iw_ff;
        if (rty_p && !rty_d_ff) begin
            nxt_defr = 32'h0;
        end
        if (!irq_ff) begin
            if (s[5] && !ack_p && !nak_p) begin
                nxt_irq = 1'b1;
                nxt_ich = s[4:0];
                nxt_iw = (mode_ff && pb_ff[s[4:0]] && lb_ff[s[4:0]][5:0] != 6'h00)
                    ? lb_ff[s[4:0]] : la_ff[s[4:0]];
            end
        end else if (ack_p) begin
            nxt_irq = 1'b0;
            nxt_pend[ich_ff] = 1'b0;
            nxt_pb[ich_ff] = 1'b0;
            nxt_rtd[ich_ff] = 1'b0;
            if (rtd_ff[ich_ff]) begin
                nxt_dcnt = dcnt_ff - 8'h01;
            end
        end else if (nak_p) begin
            nxt_irq = 1'b0;
            nxt_defr[ich_ff] = 1'b1;
            nxt_rtd[ich_ff] = 1'b1;
            if (!rtd_ff[ich_ff]) begin
                nxt_dcnt = dcnt_ff + 8'h01;
            end
        end
        nxt_pend = nxt_pend | intset;
        nxt_pb = nxt_pb | intb;
    end

    // Program dispatcher
    always_comb begin
        logic [5:0] s;
        s = pick(stp_ff);
        nxt_st = st_ff;
        nxt_stp = stp_ff;
        nxt_begun = begun_ff;
        nxt_run = run_ff;
        nxt_first = first_ff;
        nxt_go = 1'b0;
        nxt_lr2 = lr2_ff;
        if (EV_STB && EV_CODE == ces_pkg::EV_LR2) begin
            nxt_lr2[EV_CHAN[4:1]] = EV_ARG[`CES_ARG_TX];
        end
        unique case (st_ff)
            ces_pkg::ST_IDLE: begin
                if (s[5]) begin
                    nxt_st = ces_pkg::ST_REST;
                    nxt_run = s[4:0];
                    nxt_first = !begun_ff[s[4:0]];
                    nxt_stp[s[4:0]] = 1'b0;
                end
            end
            ces_pkg::ST_REST: begin
                if (CTX_DONE) begin
                    nxt_st = ces_pkg::ST_RUN;
                    nxt_go = 1'b1;
                    nxt_begun[run_ff] = 1'b1;
                end
            end
            ces_pkg::ST_RUN: begin
                if (EV_STB && EV_CODE == ces_pkg::EV_WAIT && EV_CHAN == run_ff) begin
                    nxt_st = ces_pkg::ST_IDLE;
                end
            end
        endcase
        nxt_stp = nxt_stp | startset;
        nxt_ctxr = (nxt_st == ces_pkg::ST_REST);
    end

    // State registers
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
            mode_ff <= `CES_RST_MODE;
            chsel_ff <= 5'h00;
            resp_ff <= 16'h0000;
            sec_ff <= 4'h0;
            tact_ff <= 32'h0;
            mclr_ff <= 1'b0;
            mcc_ff <= 12'h000;
            la_ff <= '{default: 16'h0000};
            lb_ff <= '{default: 16'h0000};
            pend_ff <= 32'h0;
            pb_ff <= 32'h0;
            defr_ff <= 32'h0;
            rtd_ff <= 32'h0;
            dcnt_ff <= 8'h00;
            irq_ff <= 1'b0;
            ich_ff <= 5'h00;
            iw_ff <= 16'h0000;
            st_ff <= ces_pkg::ST_IDLE;
            stp_ff <= 32'h0;
            begun_ff <= 32'h0;
            lr2_ff <= 16'h0000;
            run_ff <= 5'h00;
            first_ff <= 1'b0;
            go_ff <= 1'b0;
            ctxr_ff <= 1'b0;
            tick_ff <= '0;
        end else begin
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
            mode_ff <= nxt_mode;
            chsel_ff <= nxt_chsel;
            resp_ff <= nxt_resp;
            sec_ff <= nxt_sec;
            tact_ff <= nxt_tact;
            mclr_ff <= nxt_mclr;
            mcc_ff <= nxt_mcc;
            la_ff <= nxt_la;
            lb_ff <= nxt_lb;
            pend_ff <= nxt_pend;
            pb_ff <= nxt_pb;
            defr_ff <= nxt_defr;
            rtd_ff <= nxt_rtd;
            dcnt_ff <= nxt_dcnt;
            irq_ff <= nxt_irq;
            ich_ff <= nxt_ich;
            iw_ff <= nxt_iw;
            st_ff <= nxt_st;
            stp_ff <= nxt_stp;
            begun_ff <= nxt_begun;
            lr2_ff <= nxt_lr2;
            run_ff <= nxt_run;
            first_ff <= nxt_first;
            go_ff <= nxt_go;
            ctxr_ff <= nxt_ctxr;
            tick_ff <= nxt_tick;
        end
    end

    // Outputs, all from flip-flops
    assign WB_ACK_O = ack_ff;
    assign WB_DAT_O = dat_ff;
    assign INT_REQ = irq_ff;
    assign INT_SRC = {grp, ich_ff};
    assign INT_WORD = iw_ff;
    assign MCLR = mclr_ff;
    assign ID_CHAN = chsel_ff;
    assign CTX_REQ = ctxr_ff;
    assign CTX_CHAN = run_ff;
    assign CTX_FIRST = first_ff;
    assign PGM_GO = go_ff;
endmodule
`default_nettype wire

// ### inc/ces_cfg.svh
// Offsets, fields, reset values and timing of the scheduler
`ifndef CES_CFG_SVH
`define CES_CFG_SVH
// Register byte offsets
`define CES_A_ID 8'h00
`define CES_A_CTRL 8'h04
`define CES_A_ORDER 8'h08
`define CES_A_RESP 8'h0c
`define CES_A_CHSEL 8'h10
`define CES_A_TIMER 8'h14
`define CES_A_SEC 8'h18
`define CES_A_TACT 8'h1c
`define CES_A_DEFCNT 8'h20
// Control fields
`define CES_CTRL_MODE 0
`define CES_CTRL_MC 1
`define CES_RST_MODE 1'b0
// Order word fields
`define CES_ORD_CH 4:0
`define CES_ORD_FC 13:8
`define CES_ORD_DAT 31:16
// Function codes
`define CES_FC_CTRL 6'h01
`define CES_FC_INTA 6'h03
`define CES_FC_CHCTL 6'h05
`define CES_FC_INTB 6'h07
`define CES_FC_EXTID 6'h08
`define CES_FC_RAMCTL 6'h15
`define CES_FC_BASID 6'h26
`define CES_FC_RAMRD 6'h29
`define CES_FC_RAMWR 6'h2d
// Secondary status bits
`define CES_SEC_RAM 0
`define CES_SEC_ILLIO 1
`define CES_SEC_ILLPG 2
`define CES_SEC_PAR 3
// Event argument bits
`define CES_ARG_SCAN 7
`define CES_ARG_START 6
`define CES_ARG_INT 5
`define CES_ARG_IBIT 0
`define CES_ARG_TX 0
`define CES_ARG_SWI 2:0
// Timing
`define CES_CLK_HZ 10000000
`define CES_CLK_NS 100
`define CES_TICK_HZ 40
`define CES_TICK_CYC (`CES_CLK_HZ / `CES_TICK_HZ)
`define CES_MC_NS 250000
`define CES_MC_CYC ((`CES_MC_NS + `CES_CLK_NS - 1) / `CES_CLK_NS)
`endif

// ### inc/ces_pkg.sv
// Types shared by the scheduler
package ces_pkg;
    // Engine event codes
    typedef enum logic [3:0] {EV_BLOCK, EV_DSS, EV_PROGRAM_INTERRUPT_INSTRUCTION, EV_CCB, EV_BLOCK_HANDOVER_INSTRUCTION,
        EV_LR2, EV_SWINT, EV_ILL, EV_PAR, EV_WAIT} ces_ev_e;
    // Dispatcher states
    typedef enum logic [1:0] {ST_IDLE, ST_REST, ST_RUN} ces_st_e;
endpackage

// ### verification/ces_sched_assertions.sv
// Port checker for the channel event scheduler
`timescale 1ns/10ps
`default_nettype none
module ces_sched_assertions (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_B,
    // Watched ports
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic BUS_ACK,
    input wire logic BUS_NAK,
    input wire logic INT_REQ,
    input wire logic [9:0] INT_SRC,
    input wire logic [15:0] INT_WORD,
    input wire logic MCLR,
    input wire logic CTX_DONE,
    input wire logic CTX_REQ,
    input wire logic [4:0] CTX_CHAN,
    input wire logic PGM_GO
);
    localparam int MC_CYC = 2500; // Clear length in cycles
    logic [11:0] mc_cnt_ff, nxt_mc_cnt; // Clear cycles so far
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    // Count clear cycles, restart when low
    always_comb begin
        nxt_mc_cnt = MCLR ? mc_cnt_ff + 12'h001 : 12'h000;
    end
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            mc_cnt_ff <= 12'h000;
        end else begin
            mc_cnt_ff <= nxt_mc_cnt;
        end
    end
    property p_ack_next;
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_pulse;
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_int_hold;
        INT_REQ && $past(INT_REQ) |-> $stable(INT_WORD) && $stable(INT_SRC);
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("transfer changed");
    property p_int_end;
        $fell(INT_REQ) |-> $past(BUS_ACK, 2) || $past(BUS_NAK, 2) || $past(BUS_ACK, 3)
            || $past(BUS_NAK, 3);
    endproperty
    a_int_end: assert property (p_int_end) else $error("transfer dropped early");
    property p_mc_min;
        $fell(MCLR) |-> mc_cnt_ff >= MC_CYC;
    endproperty
    a_mc_min: assert property (p_mc_min) else $error("clear too short");
    property p_mc_max;
        MCLR |-> mc_cnt_ff < MC_CYC;
    endproperty
    a_mc_max: assert property (p_mc_max) else $error("clear too long");
    property p_go_done;
        CTX_REQ && CTX_DONE |=> PGM_GO && !CTX_REQ;
    endproperty
    a_go_done: assert property (p_go_done) else $error("start missing");
    property p_go_cause;
        PGM_GO |-> $past(CTX_REQ && CTX_DONE) ##1 !PGM_GO;
    endproperty
    a_go_cause: assert property (p_go_cause) else $error("start unrestored");
    property p_ctx_hold;
        CTX_REQ && !CTX_DONE |=> CTX_REQ && $stable(CTX_CHAN);
    endproperty
    a_ctx_hold: assert property (p_ctx_hold) else $error("restore lost");
endmodule
`default_nettype wire

// ### verification/ces_cpu_model.sv
// Processor side model: answers interrupts and context restores
`timescale 1ns/10ps
`default_nettype none
module ces_cpu_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Scenario controls
    input wire logic nak_mode,
    input wire logic slow,
    // Interrupt transfer
    input wire logic int_req,
    output logic bus_ack,
    output logic bus_nak,
    // Context restore
    input wire logic ctx_req,
    output logic ctx_done
);
    logic [3:0] i_cnt_ff; // Answer delay
    logic [3:0] c_cnt_ff; // Restore delay
    // Accept or reject, answer held until the transfer drops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            i_cnt_ff <= 4'h0;
            bus_ack <= 1'b0;
            bus_nak <= 1'b0;
        end else if (!int_req) begin
            i_cnt_ff <= 4'h0;
            bus_ack <= 1'b0;
            bus_nak <= 1'b0;
        end else if (i_cnt_ff == (slow ? 4'h6 : 4'h1)) begin
            bus_ack <= !nak_mode;
            bus_nak <= nak_mode;
        end else begin
            i_cnt_ff <= i_cnt_ff + 4'h1;
        end
    end
    // One done pulse per restore request
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            c_cnt_ff <= 4'h0;
            ctx_done <= 1'b0;
        end else begin
            c_cnt_ff <= ctx_req ? c_cnt_ff + 4'h1 : 4'h0;
            ctx_done <= ctx_req && c_cnt_ff == (slow ? 4'h9 : 4'h2);
        end
    end
endmodule
`default_nettype wire

// ### verification/tb_ces_sched.sv
// Testbench for the channel event scheduler
`timescale 1ns/10ps
`default_nettype none
`include "ces_cfg.svh"
module tb_ces_sched;
    localparam logic [15:0] BID = 16'h4d21; // Arbitrary value
    logic MCLK, RST_B, req, we, retry, ev_stb, nak_mode, slow, b_ack, b_nak, c_done;
    logic present, par_only, fw_bad, i_req, c_req, c_first, go, mclr;
    logic [7:0] adr, ev_arg, adp_id, pack_id;
    logic [31:0] wdat, rdat, svc, mask, rd_o;
    logic [4:0] grp, ev_chan, c_chan, ch, id_ch;
    logic [9:0] i_src;
    logic [15:0] i_word;
    logic ack_o;
    ces_pkg::ces_ev_e ev_code;
    logic [7:0] xid [3] = '{8'h00, 8'h01, 8'hbc};
    int errors = 0;
    int checked = 0;
    int cyc;
    // Free-running clock
    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end
    ces_sched #(.TICK_CYC(20), .BASIC_ID(BID)) i_dut (.MCLK, .RST_B,
        .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
        .WB_DAT_I(wdat), .WB_DAT_O(rd_o), .WB_ACK_O(ack_o), .GROUP_SW(grp), .SVC_REQ(svc),
        .BUS_ACK(b_ack), .BUS_NAK(b_nak), .BUS_RETRY(retry), .ADP_ID(adp_id),
        .PACK_ID(pack_id), .ADP_PRESENT(present), .ADP_PAR_ONLY(par_only),
        .ADP_FW_BAD(fw_bad), .INT_REQ(i_req), .INT_SRC(i_src), .INT_WORD(i_word),
        .MCLR(mclr), .ID_CHAN(id_ch), .EV_STB(ev_stb), .EV_CODE(ev_code), .EV_CHAN(ev_chan),
        .EV_ARG(ev_arg), .CTX_DONE(c_done), .CTX_REQ(c_req), .CTX_CHAN(c_chan),
        .CTX_FIRST(c_first), .PGM_GO(go));
    ces_cpu_model i_cpu (.clk(MCLK), .rst_b(RST_B), .nak_mode, .slow,
        .int_req(i_req), .bus_ack(b_ack), .bus_nak(b_nak), .ctx_req(c_req),
        .ctx_done(c_done));
    // Verdict and end of run
    task automatic end_sim();
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Value compare
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Wishbone classic cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge MCLK);
        while (ack_o !== 1'b1) begin
            n++;
            if (n > 20) begin
                errors++;
                end_sim();
            end
            @(posedge MCLK);
        end
        rdat = rd_o;
        req <= 1'b0;
        @(posedge MCLK);
    endtask
    // Register read and compare
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        cmp(rdat, exp);
    endtask
    // Order word: data, function, channel
    task automatic order(input logic [5:0] fc, input logic [4:0] c, input logic [15:0] d);
        wb(1'b1, `CES_A_ORDER, {d, 2'b00, fc, 3'b000, c});
    endtask
    // One-cycle engine event
    task automatic ev(input ces_pkg::ces_ev_e e, input logic [4:0] c, input logic [7:0] a);
        ev_stb <= 1'b1;
        ev_code <= e;
        ev_chan <= c;
        ev_arg <= a;
        @(posedge MCLK);
        ev_stb <= 1'b0;
        @(posedge MCLK);
    endtask
    // Watched output levels
    logic [3:0] obs;
    assign obs = {mclr, go, c_req, i_req};
    // Bounded wait for a level
    task automatic wt(input int s, input logic v, input int lim);
        cyc = 0;
        while (obs[s] !== v) begin
            cyc++;
            if (cyc > lim) begin
                errors++;
                end_sim();
            end
            @(posedge MCLK);
        end
    endtask
    // Accepted interrupt, channel 3
    task automatic int_cycle();
        wt(0, 1'b1, 60);
        cmp({16'h0, i_word}, 32'h1234);
        wt(0, 1'b0, 60);
    endtask
    // Main sequence
    initial begin
        {req, we, retry, ev_stb, nak_mode, slow, par_only, fw_bad} = '0;
        {adr, ev_arg, wdat, svc, ev_chan} = '0;
        ev_code = ces_pkg::EV_BLOCK;
        RST_B = 1'b0;
        grp = 5'h15;
        present = 1'b1;
        adp_id = 8'h3c;
        pack_id = 8'h7e;
        repeat (5) @(posedge MCLK);
        RST_B <= 1'b1;
        repeat (3) @(posedge MCLK);
        rd(`CES_A_ID, {16'h0, BID});
        order(`CES_FC_BASID, 5'd0, 16'h0);
        rd(`CES_A_RESP, {16'h0, BID});
        for (int i = 0; i < 3; i++) begin
            present <= (i != 0);
            par_only <= (i == 1);
            fw_bad <= (i == 2);
            repeat (4) @(posedge MCLK);
            order(`CES_FC_EXTID, 5'd0, 16'h0);
            rd(`CES_A_RESP, {16'h0, xid[i], 8'h7e});
        end
        order(`CES_FC_INTA, 5'd3, 16'h1234);
        nak_mode <= 1'b1;
        ev(ces_pkg::EV_BLOCK, 5'd3, 8'h00);
        wt(0, 1'b1, 60);
        cmp({22'h0, i_src}, {22'h0, 5'h15, 5'd3});
        cmp({16'h0, i_word}, 32'h1234);
        wt(0, 1'b0, 60);
        nak_mode <= 1'b0;
        rd(`CES_A_DEFCNT, 32'h1);
        retry <= 1'b1;
        repeat (3) @(posedge MCLK);
        retry <= 1'b0;
        int_cycle();
        rd(`CES_A_DEFCNT, 32'h0);
        ev(ces_pkg::EV_PROGRAM_INTERRUPT_INSTRUCTION, 5'd3, 8'h00);
        int_cycle();
        ev(ces_pkg::EV_DSS, 5'd3, 8'h20);
        int_cycle();
        ev(ces_pkg::EV_CCB, 5'd3, 8'h01);
        int_cycle();
        wb(1'b1, `CES_A_CTRL, 32'h1);
        ev(ces_pkg::EV_BLOCK_HANDOVER_INSTRUCTION, 5'd3, 8'h01);
        int_cycle();
        wb(1'b1, `CES_A_CTRL, 32'h0);
        order(6'h3f, 5'd3, 16'h0);
        int_cycle();
        order(`CES_FC_RAMRD, 5'd3, 16'h0);
        int_cycle();
        ev(ces_pkg::EV_ILL, 5'd3, 8'h00);
        int_cycle();
        ev(ces_pkg::EV_PAR, 5'd3, 8'h00);
        int_cycle();
        rd(`CES_A_SEC, 32'hf);
        wb(1'b1, `CES_A_SEC, 32'hf);
        rd(`CES_A_SEC, 32'h0);
        wb(1'b1, `CES_A_CHSEL, 32'h4);
        cmp({27'h0, id_ch}, 32'h4);
        wb(1'b1, `CES_A_TIMER, 32'h2);
        wt(1, 1'b1, 100);
        cmp({31'h0, cyc > 16 && cyc < 46}, 32'h1);
        cmp({27'h0, c_chan}, 32'h4);
        cmp({31'h0, c_first}, 32'h1);
        wt(2, 1'b1, 20);
        rd(`CES_A_TACT, 32'h10);
        ev(ces_pkg::EV_WAIT, 5'd4, 8'h00);
        repeat (50) @(posedge MCLK);
        rd(`CES_A_TIMER, 32'h0);
        wb(1'b1, `CES_A_TIMER, 32'h9);
        order(`CES_FC_CHCTL, 5'd4, 16'h0000);
        rd(`CES_A_TIMER, 32'h0);
        order(`CES_FC_CHCTL, 5'd6, 16'h0001);
        wt(1, 1'b1, 50);
        cmp({27'h0, c_chan}, 32'h6);
        wt(2, 1'b1, 20);
        slow <= 1'b1;
        svc[7] <= 1'b1;
        ev(ces_pkg::EV_SWINT, 5'd8, 8'h01);
        ev(ces_pkg::EV_DSS, 5'd9, 8'hc0);
        ev(ces_pkg::EV_LR2, 5'd10, 8'h01);
        order(`CES_FC_CHCTL, 5'd6, 16'h0001);
        ev(ces_pkg::EV_WAIT, 5'd6, 8'h00);
        mask = '0;
        repeat (5) begin
            wt(1, 1'b1, 200);
            ch = c_chan;
            mask[ch] = 1'b1;
            cmp({31'h0, c_first}, {31'h0, ch != 5'd6});
            wt(2, 1'b1, 50);
            ev(ces_pkg::EV_WAIT, ch, 8'h00);
        end
        cmp(mask, 32'h0bc0);
        wb(1'b1, `CES_A_CTRL, 32'h2);
        rd(`CES_A_CTRL, 32'h2);
        wt(3, 1'b0, 3000);
        cmp({31'h0, cyc > 2490}, 32'h1);
        rd(8'hfc, 32'h0);
        end_sim();
    end
endmodule
bind ces_sched ces_sched_assertions i_chk (.MCLK, .RST_B, .WB_CYC_I, .WB_STB_I, .WB_ACK_O,
    .BUS_ACK, .BUS_NAK, .INT_REQ, .INT_SRC, .INT_WORD, .MCLR, .CTX_DONE, .CTX_REQ, .CTX_CHAN,
    .PGM_GO);
`default_nettype wire
